// ---- design/spbr_regs.svh ----
// Purpose: register map, field layout, reset values and timing counts
// Assumes: 16-bit register data, 4-bit word address
// Notes: definitions only
`ifndef SPBR_REGS_SVH
`define SPBR_REGS_SVH

// register addresses
`define SPBR_A_CFG 4'h0
`define SPBR_A_BAUD 4'h1
`define SPBR_A_BRKTO 4'h2
`define SPBR_A_TXD 4'h3
`define SPBR_A_RXD 4'h4
`define SPBR_A_STAT 4'h5

// reset values
`define SPBR_RST_CFG 5'h00
`define SPBR_RST_BAUD 16'h01D8
`define SPBR_RST_BRKTO 16'h0064

// status bit positions
`define SPBR_ST_TXBUSY 0
`define SPBR_ST_RXVAL 1
`define SPBR_ST_PERR 2
`define SPBR_ST_FERR 3
`define SPBR_ST_OVR 4
`define SPBR_ST_BRK 5

// parity modes
`define SPBR_PAR_NONE 2'h0
`define SPBR_PAR_ODD 2'h1
`define SPBR_PAR_EVEN 2'h2

// oversampling: mid-bit tick, last tick, last data bit
`define SPBR_OVS_MID 4'h7
`define SPBR_OVS_LAST 4'hF
`define SPBR_BIT_LAST 3'h7

// baud accumulator modulus: 16x tick = setting * 16 / 4.096 ms
`define SPBR_ACC_MOD 17'h03200

// timing: clock period and break timeout unit
`define SPBR_CLK_NS 20
`define SPBR_BRK_UNIT_US 1000
`define SPBR_BRK_UNIT_CYC (`SPBR_BRK_UNIT_US * 1000 / `SPBR_CLK_NS)

`endif

// ---- design/spbr_pkg.sv ----
// Purpose: shared types of the serial port
// Assumes: constants come from spbr_regs.svh
// Notes: no import, use spbr_pkg::name
package spbr_pkg;

   // configuration word, low bits of the config register
   typedef struct packed {
      logic brk;        // hold transmit line low when idle
      logic stop2;      // two stop bits
      logic [1:0] par;  // parity mode
      logic flow;       // request/clear-to-send handshake
   } spbr_cfg_t;

   // frame state, shared by transmitter and receiver
   typedef enum logic [2:0] {
      SPBR_IDLE = 3'h0,
      SPBR_START = 3'h1,
      SPBR_DATA = 3'h2,
      SPBR_PAR = 3'h3,
      SPBR_STOP = 3'h4,
      SPBR_STOP2 = 3'h5
   } spbr_state_t;

   // receive error flags of one character
   typedef struct packed {
      logic perr;
      logic ferr;
   } spbr_rxerr_t;

endpackage : spbr_pkg

// ---- design/spbr_baud.sv ----
// Purpose: fractional 16x oversampling tick from the baud rate setting
// Assumes: 50 MHz clock
// Notes: tick rate is setting * 3906.25 per second, exact for settings up to the modulus
`timescale 1ns/10ps
`include "spbr_regs.svh"
module spbr_baud (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   // rate
   input wire logic [15:0] setting_in,
   output logic tick_out
);

   logic [16:0] acc_q;
   logic [16:0] acc_d;
   logic [16:0] sum;
   logic wrap;

   // phase accumulator, wraps at the modulus
   // programmable rate range
   assign sum = acc_q + {1'b0, setting_in};
   assign wrap = (sum >= `SPBR_ACC_MOD);
   assign acc_d = wrap ? (sum - `SPBR_ACC_MOD) : sum;

   // accumulator and tick flops
   // standard settings give rates
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         acc_q <= 17'h00000;
         tick_out <= 1'b0;
      end else begin
         acc_q <= acc_d;
         tick_out <= wrap;
      end
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);

   acc_in_range_a: assert property (acc_q < `SPBR_ACC_MOD)
      else $error("baud accumulator out of range");
   tick_follows_wrap_a: assert property (wrap |=> tick_out)
      else $error("baud tick missing after wrap");

endmodule : spbr_baud

// ---- design/spbr_top.sv ----
// Contract
// - one receive line in, one transmit out
// - optional active-low rts/cts handshake
// - 8 data bits, parity, 1 or 2 stops
// - baud 1200 to 1.5M, tight error
// - break is receive line held low, timed
// - break beyond timeout resets the module
// - transmitter can send break, line low
// - standard settings map to standard rates
// - any in-range setting is selectable
//
// Purpose: serial port with break detection and break-driven self reset
// Assumes: serial inputs synchronous to ref_clk_in, 50 MHz
// Notes: reads return data one cycle after the read strobe
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "spbr_regs.svh"
module spbr_top #(
   parameter int BRK_UNIT_CYC = `SPBR_BRK_UNIT_CYC
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   // register port
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   // serial lines
   input wire logic rx_in,
   output logic tx_out,
   input wire logic cts_n_in,
   output logic rts_n_out,
   // system
   output logic reset_req_out
);

   // parity bit for a byte under a mode
   function automatic logic par_bit(input logic [7:0] d,
                                    input logic [1:0] mode);
      par_bit = (^d) ^ (mode == `SPBR_PAR_ODD);
   endfunction : par_bit

   spbr_pkg::spbr_cfg_t cfg_q;
   logic [15:0] baud_q;
   logic [15:0] brkto_q;
   logic tick;
   logic srst;
   logic brk_fire;

   // break timer state, survives the self reset
   logic [31:0] unit_cnt_q;
   logic [15:0] brk_units_q;
   logic fired_q;

   // transmitter state
   spbr_pkg::spbr_state_t tx_st_q;
   logic [7:0] tx_sh_q;
   logic [3:0] tx_ovs_q;
   logic [2:0] tx_bit_q;
   logic tx_pend_q;
   logic [7:0] tx_buf_q;

   // receiver state
   spbr_pkg::spbr_state_t rx_st_q;
   logic [7:0] rx_sh_q;
   logic [3:0] rx_ovs_q;
   logic [2:0] rx_bit_q;
   logic [7:0] rx_data_q;
   logic rx_val_q;
   spbr_pkg::spbr_rxerr_t rx_err_q;
   logic ovr_q;
   logic brk_seen_q;

   // bus decode
   logic wr_cfg, wr_baud, wr_brkto, wr_txd, wr_stat, rd_rxd;
   assign wr_cfg = wr_in && (addr_in == `SPBR_A_CFG);
   assign wr_baud = wr_in && (addr_in == `SPBR_A_BAUD);
   assign wr_brkto = wr_in && (addr_in == `SPBR_A_BRKTO);
   assign wr_txd = wr_in && (addr_in == `SPBR_A_TXD);
   assign wr_stat = wr_in && (addr_in == `SPBR_A_STAT);
   assign rd_rxd = rd_in && (addr_in == `SPBR_A_RXD);

   // internal reset: pin reset or break timeout
   assign srst = !nrst_in || fired_q && reset_req_out;

   spbr_baud u_baud (
      .ref_clk_in(ref_clk_in),
      .nrst_in(!srst),
      .setting_in(baud_q),
      .tick_out(tick)
   );

   // configuration registers
   always_ff @(posedge ref_clk_in) begin
      if (srst) begin
         cfg_q <= `SPBR_RST_CFG;
         baud_q <= `SPBR_RST_BAUD;
         brkto_q <= `SPBR_RST_BRKTO;
      end else begin
         if (wr_cfg) cfg_q <= wdata_in[4:0];
         if (wr_baud) baud_q <= wdata_in;
         if (wr_brkto) brkto_q <= wdata_in;
      end
   end

   // status word and read mux
   logic [15:0] stat_w;
   logic [15:0] rd_mux;
   assign stat_w = {10'h000, brk_seen_q, ovr_q, rx_err_q.ferr,
                    rx_err_q.perr, rx_val_q, tx_pend_q || tx_st_q != 
                    spbr_pkg::SPBR_IDLE};
   always_comb begin
      case (addr_in)
         `SPBR_A_CFG: rd_mux = {11'h000, cfg_q};
         `SPBR_A_BAUD: rd_mux = baud_q;
         `SPBR_A_BRKTO: rd_mux = brkto_q;
         `SPBR_A_RXD: rd_mux = {8'h00, rx_data_q};
         `SPBR_A_STAT: rd_mux = stat_w;
         default: rd_mux = 16'h0000;
      endcase
   end

   // read data register, valid the cycle after the strobe
   always_ff @(posedge ref_clk_in) begin
      if (srst) rdata_out <= 16'h0000;
      else if (rd_in) rdata_out <= rd_mux;
   end

   // break timer: counts low time in units, fires once per break
   // measure low duration
   assign brk_fire = !rx_in && !fired_q && (brk_units_q > brkto_q);
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in || rx_in) begin
         unit_cnt_q <= 32'h00000000;
         brk_units_q <= 16'h0000;
         fired_q <= 1'b0;
         reset_req_out <= 1'b0;
      end else begin
         reset_req_out <= brk_fire;
         if (brk_fire) fired_q <= 1'b1;
         if (unit_cnt_q == 32'(BRK_UNIT_CYC - 1)) begin
            unit_cnt_q <= 32'h00000000;
            if (brk_units_q != 16'hFFFF)
               brk_units_q <= brk_units_q + 16'h0001;
         end else begin
            unit_cnt_q <= unit_cnt_q + 32'h00000001;
         end
      end
   end

   // transmit frame sequencer
   logic tx_go;
   assign tx_go = tx_pend_q && (!cfg_q.flow || !cts_n_in);
   always_ff @(posedge ref_clk_in) begin
      if (srst) begin
         tx_st_q <= spbr_pkg::SPBR_IDLE;
         tx_sh_q <= 8'h00;
         tx_ovs_q <= 4'h0;
         tx_bit_q <= 3'h0;
         tx_pend_q <= 1'b0;
         tx_buf_q <= 8'h00;
      end else begin
         if (wr_txd && !tx_pend_q) begin
            tx_buf_q <= wdata_in[7:0];
            tx_pend_q <= 1'b1;
         end
         if (tick) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            case (tx_st_q)
               spbr_pkg::SPBR_IDLE: begin
                  tx_ovs_q <= 4'h0;
                  if (tx_go) begin
                     tx_st_q <= spbr_pkg::SPBR_START;
                     tx_sh_q <= tx_buf_q;
                     tx_pend_q <= 1'b0;
                  end
               end
               spbr_pkg::SPBR_START: begin
                  if (tx_ovs_q == `SPBR_OVS_LAST) begin
                     tx_st_q <= spbr_pkg::SPBR_DATA;
                     tx_bit_q <= 3'h0;
                  end
               end
               spbr_pkg::SPBR_DATA: begin
                  if (tx_ovs_q == `SPBR_OVS_LAST) begin
                     tx_bit_q <= tx_bit_q + 3'h1;
                     if (tx_bit_q == `SPBR_BIT_LAST)
                        tx_st_q <= (cfg_q.par == `SPBR_PAR_NONE) ?
                                   spbr_pkg::SPBR_STOP :
                                   spbr_pkg::SPBR_PAR;
                  end
               end
               spbr_pkg::SPBR_PAR: begin
                  if (tx_ovs_q == `SPBR_OVS_LAST)
                     tx_st_q <= spbr_pkg::SPBR_STOP;
               end
               spbr_pkg::SPBR_STOP: begin
                  if (tx_ovs_q == `SPBR_OVS_LAST)
                     tx_st_q <= cfg_q.stop2 ? spbr_pkg::SPBR_STOP2 :
                                spbr_pkg::SPBR_IDLE;
               end
               spbr_pkg::SPBR_STOP2: begin
                  if (tx_ovs_q == `SPBR_OVS_LAST)
                     tx_st_q <= spbr_pkg::SPBR_IDLE;
               end
               default: tx_st_q <= spbr_pkg::SPBR_IDLE;
            endcase
         end
      end
   end

   // transmit line level from state
   // start, lsb first, parity, stop
   logic tx_d;
   assign tx_d = (tx_st_q == spbr_pkg::SPBR_IDLE) ? !cfg_q.brk :
                 (tx_st_q == spbr_pkg::SPBR_START) ? 1'b0 :
                 (tx_st_q == spbr_pkg::SPBR_DATA) ? tx_sh_q[tx_bit_q] :
                 (tx_st_q == spbr_pkg::SPBR_PAR) ?
                 par_bit(tx_sh_q, cfg_q.par) : 1'b1;

   // receive sample points
   logic rx_mid, rx_end, rx_done, rx_perr;
   assign rx_mid = tick && (rx_ovs_q == `SPBR_OVS_MID);
   assign rx_end = tick && (rx_ovs_q == `SPBR_OVS_LAST);
   assign rx_done = rx_end && (rx_st_q == spbr_pkg::SPBR_STOP);
   assign rx_perr = rx_end && (rx_st_q == spbr_pkg::SPBR_PAR) &&
                    (rx_in != par_bit(rx_sh_q, cfg_q.par));

   // receive frame sequencer, samples each bit mid-way
   // data in on receive line
   always_ff @(posedge ref_clk_in) begin
      if (srst) begin
         rx_st_q <= spbr_pkg::SPBR_IDLE;
         rx_sh_q <= 8'h00;
         rx_ovs_q <= 4'h0;
         rx_bit_q <= 3'h0;
      end else if (tick) begin
         rx_ovs_q <= rx_ovs_q + 4'h1;
         case (rx_st_q)
            spbr_pkg::SPBR_IDLE: begin
               rx_ovs_q <= 4'h0;
               if (!rx_in) rx_st_q <= spbr_pkg::SPBR_START;
            end
            spbr_pkg::SPBR_START: begin
               // mid start bit restarts the count, so every later
               // sample lands mid-bit, clear of the edges
               if (rx_mid) begin
                  rx_ovs_q <= 4'h0;
                  rx_st_q <= rx_in ? spbr_pkg::SPBR_IDLE :
                             spbr_pkg::SPBR_DATA;
                  rx_bit_q <= 3'h0;
               end
            end
            spbr_pkg::SPBR_DATA: begin
               if (rx_end) begin
                  rx_sh_q <= {rx_in, rx_sh_q[7:1]};
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == `SPBR_BIT_LAST)
                     rx_st_q <= (cfg_q.par == `SPBR_PAR_NONE) ?
                                spbr_pkg::SPBR_STOP :
                                spbr_pkg::SPBR_PAR;
               end
            end
            spbr_pkg::SPBR_PAR: begin
               if (rx_end) rx_st_q <= spbr_pkg::SPBR_STOP;
            end
            spbr_pkg::SPBR_STOP: begin
               if (rx_end) rx_st_q <= spbr_pkg::SPBR_IDLE;
            end
            default: rx_st_q <= spbr_pkg::SPBR_IDLE;
         endcase
      end
   end

   // receive holding register and sticky flags, set wins over clear
   // parity and stop checks
   always_ff @(posedge ref_clk_in) begin
      if (srst) begin
         rx_data_q <= 8'h00;
         rx_val_q <= 1'b0;
         rx_err_q <= 2'h0;
         ovr_q <= 1'b0;
         brk_seen_q <= 1'b0;
      end else begin
         if (rd_rxd) rx_val_q <= 1'b0;
         if (wr_stat && wdata_in[`SPBR_ST_PERR]) rx_err_q.perr <= 1'b0;
         if (wr_stat && wdata_in[`SPBR_ST_FERR]) rx_err_q.ferr <= 1'b0;
         if (wr_stat && wdata_in[`SPBR_ST_OVR]) ovr_q <= 1'b0;
         if (wr_stat && wdata_in[`SPBR_ST_BRK]) brk_seen_q <= 1'b0;
         if (rx_perr) rx_err_q.perr <= 1'b1;
         if (rx_done) begin
            rx_data_q <= rx_sh_q;
            rx_val_q <= 1'b1;
            if (rx_val_q && !rd_rxd) ovr_q <= 1'b1;
            if (!rx_in) rx_err_q.ferr <= 1'b1;
            if (!rx_in && rx_sh_q == 8'h00) brk_seen_q <= 1'b1;
         end
      end
   end

   // serial output flops
   // request-to-send low when room
   always_ff @(posedge ref_clk_in) begin
      if (srst) begin
         tx_out <= 1'b1;
         rts_n_out <= 1'b0;
      end else begin
         tx_out <= tx_d;
         rts_n_out <= cfg_q.flow && rx_val_q;
      end
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);

   sequence tx_launch_s;
      tick && tx_st_q == spbr_pkg::SPBR_IDLE && tx_go;
   endsequence
   sequence start_low_s;
      !tx_out [*2];
   endsequence

   tx_start_low_a: assert property (tx_launch_s |-> ##2 start_low_s)
      else $error("start bit not low");
   cts_holds_tx_a: assert property (tick && tx_st_q == spbr_pkg::SPBR_IDLE
      && cfg_q.flow && cts_n_in |=> tx_st_q == spbr_pkg::SPBR_IDLE)
      else $error("frame started without clear-to-send");
   rts_full_a: assert property (cfg_q.flow && rx_val_q && !srst
      |=> rts_n_out)
      else $error("request-to-send low while full");
   data_bits_a: assert property (tx_st_q == spbr_pkg::SPBR_DATA
      && tx_st_q != $past(tx_st_q) |-> tx_bit_q == 3'h0)
      else $error("data phase did not begin at bit zero");
   par_err_set_a: assert property (rx_perr && !srst |=> rx_err_q.perr)
      else $error("parity error not flagged");
   tx_break_low_a: assert property (cfg_q.brk && !srst
      && tx_st_q == spbr_pkg::SPBR_IDLE && !tx_go |=> !tx_out)
      else $error("break not driven low");
   brk_reset_a: assert property (brk_fire |=> reset_req_out ##1
      (baud_q == `SPBR_RST_BAUD && cfg_q == `SPBR_RST_CFG))
      else $error("break timeout did not reset");
   brk_once_a: assert property (reset_req_out |=> !reset_req_out)
      else $error("break reset repeated");
   rx_frame_a: assert property (rx_done && !srst |=> rx_val_q
      && rx_data_q == $past(rx_sh_q))
      else $error("received byte not delivered");

endmodule : spbr_top

// ---- test/spbr_host.sv ----
// Purpose: far-end serial device model
// Assumes: bit time taken from the shared rate setting
// Notes: received frames queue up for the bench
`timescale 1ns/10ps
module spbr_host (
   // clock
   input wire logic clk_in,
   // settings shared with the bench
   input wire logic [15:0] baud_in,
   input wire logic [1:0] par_in,
   input wire logic stop2_in,
   // serial lines
   input wire logic tx_in,
   input wire logic rts_n_in,
   output logic rx_out,
   output logic cts_n_out
);
   logic [9:0] got_q[$];
   logic [9:0] f;
   real start_ns = 0.0;
   real bit_w = 0.0;

   // idle line high, sender allowed
   initial begin
      rx_out = 1'b1;
      cts_n_out = 1'b0;
   end

   function automatic real bit_ns();
      return 4096000.0 / baud_in;
   endfunction : bit_ns

   task automatic send(input logic [7:0] d, input logic bad_par,
                       input logic bad_stop);
      logic [11:0] b;
      logic p;
      int n;
      int nb;
      real t;
      for (n = 0; n < 5000 && rts_n_in !== 1'b0; n++) @(posedge clk_in);
      if (rts_n_in !== 1'b0) begin
         $display("CHECK FAILED rts wait exp 0 got %b", rts_n_in);
         tb_top.error_cnt++;
         tb_top.conclude();
      end
      p = ^d ^ (par_in == 2'h1) ^ bad_par;
      if (par_in == 2'h0) b = {2'b11, ~bad_stop, d, 1'b0};
      else b = {1'b1, ~bad_stop, p, d, 1'b0};
      nb = 10 + (par_in != 2'h0) + stop2_in;
      @(posedge clk_in);
      t = $realtime;
      for (n = 0; n < nb; n++) begin
         rx_out <= b[n];
         t += bit_ns();
         while ($realtime < t) @(posedge clk_in);
      end
      rx_out <= 1'b1;
   endtask : send

   // line held low for a number of cycles
   task automatic brk(input int cyc);
      @(posedge clk_in);
      rx_out <= 1'b0;
      repeat (cyc) @(posedge clk_in);
      rx_out <= 1'b1;
   endtask : brk

   task automatic stall(input logic s);
      @(posedge clk_in);
      cts_n_out <= s;
   endtask : stall

   initial forever begin
      @(negedge tx_in);
      start_ns = $realtime;
      bit_w = -1.0;
      #(bit_ns() * 1.5);
      for (int k = 0; k < 8; k++) begin
         f[k] = tx_in;
         #(bit_ns());
      end
      f[8] = 1'b0;
      if (par_in != 2'h0) begin
         f[8] = tx_in;
         #(bit_ns());
      end
      f[9] = tx_in;
      got_q.push_back(f);
   end

   // width of the start bit
   always @(posedge tx_in) begin
      if (bit_w < 0.0) bit_w = $realtime - start_ns;
   end
endmodule : spbr_host

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for the serial port
// Assumes: break unit shortened to 10 cycles
// Notes: far end is spbr_host
`timescale 1ns/10ps
`include "spbr_regs.svh"
module tb_top;
   logic ref_clk_in, nrst_in, wr_in, rd_in, rx, cts_n, stop2, hit;
   logic tx_out, rts_n_out, reset_req_out;
   logic [3:0] addr_in;
   logic [15:0] wdata_in, rdata_out, rv, baud;
   logic [1:0] par;
   logic [7:0] dd;
   logic [9:0] f;
   int error_cnt, n_tests, i, k;
   real e;
   logic [15:0] bs [3] = '{16'h0027, 16'h01D8, 16'h0EBF};
   real br [3] = '{9600.0, 115200.0, 921600.0};

   // design with short break unit
   spbr_top #(.BRK_UNIT_CYC(10)) i_spbr_top (.ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rx_in(rx),
      .tx_out(tx_out), .cts_n_in(cts_n), .rts_n_out(rts_n_out),
      .reset_req_out(reset_req_out));

   // far-end device
   spbr_host i_spbr_host (.clk_in(ref_clk_in), .baud_in(baud),
      .par_in(par), .stop2_in(stop2), .tx_in(tx_out),
      .rts_n_in(rts_n_out), .rx_out(rx), .cts_n_out(cts_n));

   // clock, 20 ns
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   // remember any self-reset pulse
   always @(posedge ref_clk_in) begin
      if (nrst_in !== 1'b1) hit <= 1'b0;
      else if (reset_req_out === 1'b1) hit <= 1'b1;
   end

   task automatic chk(input string nm, input logic [15:0] x, g);
      n_tests++;
      if (g !== x) begin
         $display("CHECK FAILED %s exp %h got %h", nm, x, g);
         error_cnt++;
      end
   endtask : chk

   task automatic conclude();
      $display("tests %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask : wr

   task automatic rc(input logic [3:0] a, input logic [15:0] x);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1 rv = rdata_out;
      if (x !== 16'hFFFF) chk("register", x, rv);
   endtask : rc

   task automatic cfg(input logic [4:0] v, input logic [15:0] b);
      wr(`SPBR_A_CFG, {11'h000, v});
      wr(`SPBR_A_BAUD, b);
      par = v[2:1];
      stop2 = v[3];
      baud = b;
   endtask : cfg

   task automatic wait_rx();
      for (k = 0; k < 60000 && i_spbr_host.got_q.size() == 0; k++)
         @(posedge ref_clk_in);
      if (i_spbr_host.got_q.size() == 0) begin
         $display("CHECK FAILED tx frame exp 1 got 0");
         error_cnt++;
         conclude();
      end
      f = i_spbr_host.got_q.pop_front();
   endtask : wait_rx

   initial begin
      {nrst_in, wr_in, rd_in, addr_in, wdata_in} = '0;
      {par, stop2, baud, error_cnt, n_tests} = {3'h0, 16'h01D8, 64'h0};
      repeat (8) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      wr(4'hF, 16'h1234);
      rc(4'hF, 16'h0000);
      rc(`SPBR_A_CFG, 16'h0000);
      rc(`SPBR_A_BAUD, 16'h01D8);
      rc(`SPBR_A_BRKTO, 16'h0064);
      chk("idle line", 16'h0001, {15'h0, tx_out});
      $display("test reset done");
      for (i = 0; i < 3; i++) begin
         cfg(5'h00, bs[i]);
         wr(`SPBR_A_TXD, 16'h0001);
         wait_rx();
         e = 1.0e9 / br[i];
         chk("bit time", 16'h0001, {15'h0, i_spbr_host.bit_w - e < e * 0.01
            + 25.0 && e - i_spbr_host.bit_w < e * 0.01 + 25.0});
         repeat (3000) @(posedge ref_clk_in);
      end
      $display("test baud done");
      for (i = 0; i < 6; i++) begin
         cfg({1'b0, i[0], i[2:1], 1'b0}, 16'h0EBF);
         dd = 8'hA5 + i[7:0];
         wr(`SPBR_A_TXD, {8'h00, dd});
         wait_rx();
         chk("tx frame", {6'h00, 1'b1, par != 2'h0 && (^dd ^ par == 2'h1),
            dd}, {6'h00, f});
         repeat (150) @(posedge ref_clk_in);
         i_spbr_host.send(8'h3C + i[7:0], 1'b0, 1'b0);
         rc(`SPBR_A_STAT, 16'h0002);
         rc(`SPBR_A_RXD, 16'h003C + i[15:0]);
      end
      $display("test formats done");
      cfg(5'h04, 16'h0EBF);
      i_spbr_host.send(8'h55, 1'b1, 1'b0);
      rc(`SPBR_A_STAT, 16'h0006);
      rc(`SPBR_A_RXD, 16'hFFFF);
      wr(`SPBR_A_STAT, 16'h003C);
      rc(`SPBR_A_STAT, 16'h0000);
      cfg(5'h00, 16'h0EBF);
      i_spbr_host.send(8'h55, 1'b0, 1'b1);
      rc(`SPBR_A_STAT, 16'h000A);
      rc(`SPBR_A_RXD, 16'hFFFF);
      wr(`SPBR_A_STAT, 16'h003C);
      i_spbr_host.send(8'h11, 1'b0, 1'b0);
      i_spbr_host.send(8'h22, 1'b0, 1'b0);
      rc(`SPBR_A_STAT, 16'h0012);
      rc(`SPBR_A_RXD, 16'h0022);
      wr(`SPBR_A_STAT, 16'h003C);
      $display("test errors done");
      cfg(5'h01, 16'h0EBF);
      i_spbr_host.stall(1'b1);
      wr(`SPBR_A_TXD, 16'h0077);
      repeat (1500) @(posedge ref_clk_in);
      chk("held tx", 16'h0001, {15'h0, tx_out});
      i_spbr_host.stall(1'b0);
      wait_rx();
      chk("flow frame", 16'h0277, {6'h00, f});
      repeat (150) @(posedge ref_clk_in);
      i_spbr_host.send(8'h44, 1'b0, 1'b0);
      repeat (2) @(posedge ref_clk_in);
      chk("rts full", 16'h0001, {15'h0, rts_n_out});
      rc(`SPBR_A_RXD, 16'h0044);
      repeat (2) @(posedge ref_clk_in);
      chk("rts free", 16'h0000, {15'h0, rts_n_out});
      $display("test flow done");
      cfg(5'h10, 16'h0EBF);
      repeat (3) @(posedge ref_clk_in);
      chk("tx break", 16'h0000, {15'h0, tx_out});
      cfg(5'h00, 16'h0EBF);
      repeat (3) @(posedge ref_clk_in);
      chk("tx unbreak", 16'h0001, {15'h0, tx_out});
      repeat (800) @(posedge ref_clk_in);
      i_spbr_host.got_q.delete();
      $display("test tx break done");
      i_spbr_host.brk(700);
      repeat (100) @(posedge ref_clk_in);
      rc(`SPBR_A_STAT, 16'hFFFF);
      chk("break seen", 16'h0020, rv & 16'h0020);
      chk("no reset", 16'h0000, {15'h0, hit});
      cfg(5'h04, 16'h0EBF);
      fork
         i_spbr_host.brk(1300);
         begin
            for (i = 0; i < 1100 && reset_req_out !== 1'b1; i++)
               @(posedge ref_clk_in);
            chk("reset time", 16'h0001, {15'h0, i >= 1000 && i <= 1025});
            @(posedge ref_clk_in);
            #1 chk("pulse end", 16'h0000, {15'h0, reset_req_out});
         end
      join
      rc(`SPBR_A_CFG, 16'h0000);
      rc(`SPBR_A_BAUD, 16'h01D8);
      $display("test break reset done");
      conclude();
   end
endmodule : tb_top
